// ---- twc_cfg.svh ----
`ifndef TWC_CFG_SVH
`define TWC_CFG_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TWC_OFS_STATUS 8'h00
`define TWC_OFS_CONTROL 8'h04
`define TWC_OFS_SELECT 8'h08
`define TWC_OFS_DATA 8'h0C
// ----------------------------------------
// accumulator bit n sits on data bit 17-n
// ----------------------------------------
`define TWC_WORD_W 18
`define TWC_AC_RUN 5'd5
`define TWC_AC_REV 5'd4
`define TWC_AC_FN_HI 5'd2
`define TWC_AC_FN_LO 5'd0
`define TWC_AC_SEL_HI 5'd15
`define TWC_AC_SEL_LO 5'd12
`define TWC_STAT_HI 5'd17
`define TWC_STAT_LO 5'd9
// ----------------------------------------
// pin vector positions
// ----------------------------------------
`define TWC_PIN_N 13
`define TWC_P_TP2 0
`define TWC_P_TP0 1
`define TWC_P_BLK 2
`define TWC_P_ST3 3
`define TWC_P_ST4 4
`define TWC_P_STA 5
`define TWC_P_DAT 6
`define TWC_P_PRE 7
`define TWC_P_FIN 8
`define TWC_P_CHK 9
`define TWC_P_END 10
`define TWC_P_MTF 11
`define TWC_P_RUN 12
// ----------------------------------------
// timing
// ----------------------------------------
`define TWC_CLK_MHZ 25
`define TWC_BUSY_US 480
`define TWC_STOPW_US 240
`define TWC_BUSY_CYC (`TWC_BUSY_US * `TWC_CLK_MHZ)
`define TWC_STOPW_CYC (`TWC_STOPW_US * `TWC_CLK_MHZ)
`define TWC_SKIP_SPACES 2'd2
`define TWC_NOCHK_WORDS 3'd4
`endif

// ---- twc_pkg.sv ----
`default_nettype none
package twc_pkg;
   // ----------------------------------------
   // function codes from the load-control word
   // ----------------------------------------
   typedef enum logic [2:0] {
      FN_MOVE = 3'b000,
      FN_SEARCH = 3'b001,
      FN_READ = 3'b010,
      FN_WRITE = 3'b011,
      FN_READ_EVERY = 3'b100,
      FN_WRITE_EVERY = 3'b101,
      FN_TIMING_MARK = 3'b110,
      FN_READIN = 3'b111
   } twc_func_t;
endpackage : twc_pkg
`default_nettype wire

// ---- twc_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// three-stage pin synchroniser, edge on agreement
// ----------------------------------------
module twc_sync #(
   parameter int W = 1
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [W-1:0] pinIn,
   output logic [W-1:0] levelOut,
   output logic [W-1:0] riseOut
);
   logic [W-1:0] s1_reg, s2_reg, s3_reg, lvl_reg, rise_reg;
   logic [W-1:0] lvl_next, rise_next;
   // stage one is looked at only by stage two
   always_comb
   begin
      lvl_next = lvl_reg;
      for (int i = 0; i < W; i++)
      begin
         if (s2_reg[i] == s3_reg[i])
            lvl_next[i] = s3_reg[i];
      end
      rise_next = lvl_next & ~lvl_reg;
   end
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         lvl_reg <= '0;
         rise_reg <= '0;
      end
      else
      begin
         s1_reg <= pinIn;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         lvl_reg <= lvl_next;
         rise_reg <= rise_next;
      end
   end
   assign levelOut = lvl_reg;
   assign riseOut = rise_reg;
endmodule : twc_sync
`default_nettype wire

// ---- twc_unit_dec.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// unit code to selection line; 0 and 9..15 select none
// ----------------------------------------
module twc_unit_dec (
   input wire logic [3:0] unitCode,
   output logic [7:0] unitLine
);
   always_comb
   begin
      unitLine = 8'h00;
      if (unitCode >= 4'h1 && unitCode <= 4'h8)
         unitLine[3'(unitCode - 4'h1)] = 1'b1;
   end
endmodule : twc_unit_dec
`default_nettype wire

// ---- twc_ctrl.sv ----
// Contract
// - status read returns flags and unit status
// - flags drive break, skip and status
// - block flag asks host for checksum
// - fault flag plus status names cause
// - mode keeps flagging until stop or end
// - search block mark flags and interchanges
// - each block number moved with flag
// - flag still set: missed word, fault
// - end mark sets end, stops run
// - entering write raises data flag
// - write flags only in write window
// - no stop or read during shifting
// - overrun writes reverse checksum, then resumes
// - boundary holds stop; read-flag stop waits
// - read flags in read window at strobe
// - word read moves word, clears flag
// - read to write skips two spaces
// - late first word: block flag or none
// - write to read raises dummy flag
// - select latches four bits, one line
// - run and reverse loaded, stop keeps direction
// - both bits set run reverse
// - function latched, decoded only while running
// - power clear resets all control state
// - host halt forces run off
`timescale 1ns/10ps
`default_nettype none
`include "twc_cfg.svh"
module twc_ctrl #(
   parameter int BUSY_CYC = `TWC_BUSY_CYC,
   parameter int STOPW_CYC = `TWC_STOPW_CYC
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic wbCycI,
   input wire logic wbStbI,
   input wire logic wbWeI,
   input wire logic [7:0] wbAdrI,
   input wire logic [3:0] wbSelI,
   input wire logic [31:0] wbDatI,
   output logic [31:0] wbDatO,
   output logic wbAckO,
   input wire logic [`TWC_PIN_N-1:0] tapePins,
   input wire logic unitUnable,
   input wire logic [`TWC_WORD_W-1:0] tapeWord,
   output logic [`TWC_WORD_W-1:0] writeWord,
   output logic interchangePulse,
   output logic checksumWritePulse,
   output logic shiftOnZeroPhase,
   output logic wordReadyFlag,
   output logic blockEndFlag,
   output logic faultFlag,
   output logic breakRequest,
   output logic skipEnable,
   output logic runOut,
   output logic reverseOut,
   output logic writePermit,
   output logic [7:0] modeLines,
   output logic [7:0] unitLines
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [`TWC_PIN_N-1:0] pinLvl, pinRise;
   logic [7:0] unitDec;
   twc_sync #(.W(`TWC_PIN_N)) u_sync (
      .clock(clock),
      .nrst(nrst),
      .pinIn(tapePins),
      .levelOut(pinLvl),
      .riseOut(pinRise)
   );
   logic [3:0] sel_reg, sel_next;
   twc_unit_dec u_dec (
      .unitCode(sel_reg),
      .unitLine(unitDec)
   );
   logic tp2, tp0;
   assign tp2 = pinRise[`TWC_P_TP2];
   assign tp0 = pinRise[`TWC_P_TP0];
   // ----------------------------------------
   // state
   // ----------------------------------------
   twc_pkg::twc_func_t fn_reg, fn_next;
   logic run_reg, run_next, rev_reg, rev_next, wp_reg, wp_next;
   logic df_reg, df_next, bf_reg, bf_next, ef_reg, ef_next;
   logic miss_reg, miss_next, mtf_reg, mtf_next, end_reg, end_next;
   logic dummy_reg, dummy_next, tmpRd_reg, tmpRd_next, ovr_reg, ovr_next;
   logic bnd_reg, bnd_next, hold_reg, hold_next, sz_reg, sz_next;
   logic pend_reg, pend_next, ack_reg, ack_next, xch_reg, xch_next;
   logic cks_reg, cks_next;
   logic [1:0] skip_reg, skip_next;
   logic [2:0] nochk_reg, nochk_next;
   logic [5:0] pendCmd_reg, pendCmd_next;
   logic [15:0] busy_reg, busy_next, stopw_reg, stopw_next;
   logic [`TWC_WORD_W-1:0] io_reg, io_next, wr_reg, wr_next;
   logic [31:0] dat_reg, dat_next;
   logic [7:0] mode_reg, mode_next, unit_reg;
   // ----------------------------------------
   // decode of bus access and mode
   // ----------------------------------------
   logic act, wr, lcInstr, selInstr, wwInstr, wrdInstr, srInstr;
   logic isSearch, isRead, isWrite, rwin, wwin, raise_data_flag_pulse, inhibit;
   logic [5:0] cmd;
   logic applyCmd, cmdRun, cmdRead;
   logic [`TWC_STAT_HI-`TWC_STAT_LO:0] statWord;
   assign act = wbCycI && wbStbI && !ack_reg;
   assign wr = act && wbWeI && (&wbSelI[2:0]);
   assign lcInstr = wr && wbAdrI == `TWC_OFS_CONTROL;
   assign selInstr = wr && wbAdrI == `TWC_OFS_SELECT;
   assign wwInstr = wr && wbAdrI == `TWC_OFS_DATA;
   assign wrdInstr = act && !wbWeI && wbAdrI == `TWC_OFS_DATA;
   assign srInstr = act && !wbWeI && wbAdrI == `TWC_OFS_STATUS;
   // modes only exist while running
   assign isSearch = run_reg && fn_reg == twc_pkg::FN_SEARCH;
   assign isRead = run_reg && (tmpRd_reg || fn_reg == twc_pkg::FN_READ
      || fn_reg == twc_pkg::FN_READ_EVERY);
   assign isWrite = run_reg && !tmpRd_reg && (fn_reg == twc_pkg::FN_WRITE
      || fn_reg == twc_pkg::FN_WRITE_EVERY);
   assign rwin = pinLvl[`TWC_P_ST3] | pinLvl[`TWC_P_ST4] | pinLvl[`TWC_P_DAT]
      | pinLvl[`TWC_P_PRE] | pinLvl[`TWC_P_FIN];
   assign wwin = pinLvl[`TWC_P_STA] | pinLvl[`TWC_P_DAT];
   // raise-data-flag pulse, one per word space while the mode lasts
   assign raise_data_flag_pulse = tp2 && skip_reg == 2'd0 && !hold_reg
      && ((isSearch && pinLvl[`TWC_P_BLK])
      || (isRead && rwin)
      || (isWrite && wwin));
   // command held while shifting, in the boundary, or in the stop wait
   // bit 3 is a spare so that run and reverse keep their own slots
   assign cmd = pend_reg && !lcInstr ? pendCmd_reg
      : {wbDatI[`TWC_AC_RUN], wbDatI[`TWC_AC_REV], 1'b0,
      wbDatI[`TWC_AC_FN_HI:`TWC_AC_FN_LO]};
   assign cmdRun = cmd[5];
   assign cmdRead = cmd[2:0] == twc_pkg::FN_READ;
   assign inhibit = busy_reg != 16'h0000 || bnd_reg
      || (stopw_reg != 16'h0000 && !cmdRun);
   assign applyCmd = (lcInstr || pend_reg) && !((!cmdRun || cmdRead) && inhibit);
   assign statWord = {df_reg, bf_reg, ef_reg, rev_reg, run_reg, mtf_reg, miss_reg,
      end_reg, unitUnable};
   // ----------------------------------------
   // next-state logic
   // ----------------------------------------
   always_comb
   begin
      fn_next = fn_reg;
      run_next = run_reg;
      rev_next = rev_reg;
      wp_next = wp_reg;
      sel_next = sel_reg;
      miss_next = miss_reg;
      mtf_next = mtf_reg;
      end_next = end_reg;
      dummy_next = dummy_reg;
      tmpRd_next = tmpRd_reg;
      ovr_next = ovr_reg;
      bnd_next = bnd_reg;
      hold_next = hold_reg;
      sz_next = sz_reg;
      skip_next = skip_reg;
      nochk_next = nochk_reg;
      pend_next = pend_reg;
      pendCmd_next = pendCmd_reg;
      busy_next = busy_reg == 16'h0000 ? busy_reg : busy_reg - 16'h0001;
      stopw_next = stopw_reg == 16'h0000 ? stopw_reg : stopw_reg - 16'h0001;
      io_next = io_reg;
      wr_next = wr_reg;
      cks_next = 1'b0;
      xch_next = raise_data_flag_pulse;
      ack_next = act;
      dat_next = 32'h0000_0000;
      df_next = df_reg;
      bf_next = bf_reg;
      // host side: clears first so that sets below win
      if (wrdInstr || wwInstr)
      begin
         df_next = 1'b0;
         bf_next = 1'b0;
      end
      if (wrdInstr)
         dat_next[`TWC_WORD_W-1:0] = io_reg;
      if (srInstr)
         dat_next[`TWC_STAT_HI:`TWC_STAT_LO] = statWord;
      if (act && !wbWeI && wbAdrI == `TWC_OFS_CONTROL)
         dat_next[5:0] = {run_reg, rev_reg, 1'b0, fn_reg};
      if (act && !wbWeI && wbAdrI == `TWC_OFS_SELECT)
         dat_next[`TWC_AC_SEL_HI:`TWC_AC_SEL_LO] = sel_reg;
      if (wwInstr)
      begin
         io_next = wbDatI[`TWC_WORD_W-1:0];
         if (isWrite)
            busy_next = 16'(BUSY_CYC);
         if (isWrite && bnd_reg && !bf_reg)
            ovr_next = 1'b1;
      end
      if (selInstr)
         sel_next = wbDatI[`TWC_AC_SEL_HI:`TWC_AC_SEL_LO];
      // load control, possibly from the held copy
      if (lcInstr && !applyCmd)
      begin
         pend_next = 1'b1;
         pendCmd_next = cmd;
      end
      if (applyCmd)
      begin
         pend_next = 1'b0;
         run_next = cmdRun;
         if (cmdRun)
            rev_next = cmd[4];
         fn_next = twc_pkg::twc_func_t'(cmd[2:0]);
         miss_next = 1'b0;
         mtf_next = 1'b0;
         end_next = 1'b0;
         tmpRd_next = 1'b0;
         ovr_next = 1'b0;
         sz_next = 1'b0;
         wp_next = cmd[2:0] == twc_pkg::FN_WRITE || cmd[2:0] == twc_pkg::FN_WRITE_EVERY;
         if (cmdRun && wp_next && !isWrite)
         begin
            df_next = 1'b1;
            if (isRead)
               skip_next = `TWC_SKIP_SPACES;
         end
         if (cmdRun && cmdRead && isWrite)
         begin
            dummy_next = 1'b1;
            df_next = 1'b1;
            nochk_next = `TWC_NOCHK_WORDS;
         end
      end
      // tape side, second timing strobe
      if (tp2 && isWrite && wwin && skip_reg != 2'd0)
      begin
         skip_next = skip_reg - 2'd1;
         if (skip_reg == 2'd1 && pinLvl[`TWC_P_FIN])
            bf_next = 1'b1;
      end
      if (tp2 && isWrite && skip_reg != 2'd0 && pinLvl[`TWC_P_CHK])
      begin
         skip_next = 2'd0;
         hold_next = 1'b1;
      end
      if (tp2 && pinLvl[`TWC_P_BLK])
         hold_next = 1'b0;
      if (raise_data_flag_pulse)
      begin
         if (isRead || isSearch)
            io_next = tapeWord;
         else
            wr_next = io_reg;
         if (df_reg && !dummy_reg && !(wrdInstr || wwInstr))
            miss_next = 1'b1;
         df_next = 1'b1;
         if (isRead)
         begin
            dummy_next = 1'b0;
            if (nochk_reg != 3'd0)
               nochk_next = nochk_reg - 3'd1;
         end
      end
      // boundary between last data word and checksum
      if (tp2 && isWrite && pinLvl[`TWC_P_FIN])
         bnd_next = 1'b1;
      if (tp2 && pinLvl[`TWC_P_CHK])
      begin
         bnd_next = 1'b0;
         if ((isRead || isWrite) && !hold_reg && skip_reg == 2'd0)
         begin
            bf_next = 1'b1;
            if (isRead)
               stopw_next = 16'(STOPW_CYC);
         end
         if (isWrite && ovr_reg)
         begin
            tmpRd_next = 1'b1;
            cks_next = 1'b1;
            ovr_next = 1'b0;
         end
      end
      // overrun: back to write at the next block, shifting on zero phase
      if (tmpRd_reg && tp2 && pinLvl[`TWC_P_BLK])
      begin
         tmpRd_next = 1'b0;
         sz_next = 1'b1;
      end
      if (sz_reg && tp0 && isWrite)
         wr_next = io_reg;
      // error causes: timing mark checked only in data modes, end mark whenever running
      if (tp2 && pinLvl[`TWC_P_MTF] && (isRead || isWrite) && nochk_reg == 3'd0)
         mtf_next = 1'b1;
      if (tp2 && run_reg && pinLvl[`TWC_P_END])
      begin
         end_next = 1'b1;
         run_next = 1'b0;
      end
      if (!pinLvl[`TWC_P_RUN])
         run_next = 1'b0;
      ef_next = miss_next || mtf_next || end_next || unitUnable;
      mode_next = run_next ? 8'h01 << fn_next : 8'h00;
   end
   // ----------------------------------------
   // registers; power clear is the async reset
   // ----------------------------------------
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         fn_reg <= twc_pkg::FN_MOVE;
         run_reg <= 1'b0;
         rev_reg <= 1'b0;
         wp_reg <= 1'b0;
         sel_reg <= 4'h0;
         df_reg <= 1'b0;
         bf_reg <= 1'b0;
         ef_reg <= 1'b0;
         miss_reg <= 1'b0;
         mtf_reg <= 1'b0;
         end_reg <= 1'b0;
         dummy_reg <= 1'b0;
         tmpRd_reg <= 1'b0;
         ovr_reg <= 1'b0;
         bnd_reg <= 1'b0;
         hold_reg <= 1'b0;
         sz_reg <= 1'b0;
         skip_reg <= 2'd0;
         nochk_reg <= 3'd0;
         pend_reg <= 1'b0;
         pendCmd_reg <= 6'h00;
         busy_reg <= 16'h0000;
         stopw_reg <= 16'h0000;
         io_reg <= '0;
         wr_reg <= '0;
         dat_reg <= 32'h0000_0000;
         ack_reg <= 1'b0;
         xch_reg <= 1'b0;
         cks_reg <= 1'b0;
         mode_reg <= 8'h00;
         unit_reg <= 8'h00;
      end
      else
      begin
         fn_reg <= fn_next;
         run_reg <= run_next;
         rev_reg <= rev_next;
         wp_reg <= wp_next;
         sel_reg <= sel_next;
         df_reg <= df_next;
         bf_reg <= bf_next;
         ef_reg <= ef_next;
         miss_reg <= miss_next;
         mtf_reg <= mtf_next;
         end_reg <= end_next;
         dummy_reg <= dummy_next;
         tmpRd_reg <= tmpRd_next;
         ovr_reg <= ovr_next;
         bnd_reg <= bnd_next;
         hold_reg <= hold_next;
         sz_reg <= sz_next;
         skip_reg <= skip_next;
         nochk_reg <= nochk_next;
         pend_reg <= pend_next;
         pendCmd_reg <= pendCmd_next;
         busy_reg <= busy_next;
         stopw_reg <= stopw_next;
         io_reg <= io_next;
         wr_reg <= wr_next;
         dat_reg <= dat_next;
         ack_reg <= ack_next;
         xch_reg <= xch_next;
         cks_reg <= cks_next;
         mode_reg <= mode_next;
         unit_reg <= unitDec;
      end
   end
   // break and skip follow the flags on the same edge
   logic brk_reg;
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         brk_reg <= 1'b0;
      else
         brk_reg <= df_next || bf_next || ef_next;
   end
   // ----------------------------------------
   // outputs, all straight from flops
   // ----------------------------------------
   assign wbDatO = dat_reg;
   assign wbAckO = ack_reg;
   assign writeWord = wr_reg;
   assign interchangePulse = xch_reg;
   assign checksumWritePulse = cks_reg;
   assign shiftOnZeroPhase = sz_reg;
   assign wordReadyFlag = df_reg;
   assign blockEndFlag = bf_reg;
   assign faultFlag = ef_reg;
   assign breakRequest = brk_reg;
   assign skipEnable = brk_reg;
   assign runOut = run_reg;
   assign reverseOut = rev_reg;
   assign writePermit = wp_reg;
   assign modeLines = mode_reg;
   assign unitLines = unit_reg;
   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   chk_miss_on_flag: assert property (
      raise_data_flag_pulse && df_reg && !dummy_reg && !wrdInstr && !wwInstr |=> miss_reg && faultFlag)
      else $error("missed word not flagged");
   chk_end_stops: assert property (
      tp2 && run_reg && pinLvl[`TWC_P_END] |=> end_reg && !run_reg)
      else $error("end mark did not stop tape");
   chk_read_clears: assert property (
      wrdInstr && !raise_data_flag_pulse |=> !wordReadyFlag && wbAckO && wbDatO[17:0] == $past(io_reg))
      else $error("word read did not clear flag");
   chk_host_halt: assert property (
      !pinLvl[`TWC_P_RUN] |=> !runOut)
      else $error("run not forced off");
   chk_sel_onehot: assert property (
      $onehot0(unitLines))
      else $error("more than one unit selected");
   chk_mode_gated: assert property (
      !runOut |-> modeLines == 8'h00)
      else $error("mode asserted while stopped");
   chk_busy_holds: assert property (
      lcInstr && busy_reg > 16'h0001 && run_reg && !wbDatI[`TWC_AC_RUN]
      && pinLvl[`TWC_P_RUN] && !(tp2 && pinLvl[`TWC_P_END]) |=> runOut ##0 pend_reg)
      else $error("stop acted during shifting");
   chk_flag_xchg: assert property (
      raise_data_flag_pulse |=> interchangePulse && wordReadyFlag ##1 !interchangePulse)
      else $error("flag without interchange");
   chk_status_word: assert property (
      srInstr |=> wbDatO[17:15] == $past({df_reg, bf_reg, ef_reg}))
      else $error("status flags wrong");
   chk_break_req: assert property (
      wordReadyFlag || blockEndFlag || faultFlag |-> breakRequest && skipEnable)
      else $error("flag without break request");
   cov_search_flag: cover property (isSearch && raise_data_flag_pulse);
   cov_write_entry: cover property (lcInstr && applyCmd && wp_next ##1 wordReadyFlag);
   cov_miss: cover property ($rose(miss_reg));
   cov_held_stop: cover property ($fell(pend_reg) && !run_next);
endmodule : twc_ctrl
`default_nettype wire

// ---- twc_tape_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// tape side: timing strobe and mark levels
// ----------------------------------------
module twc_tape_model (
   input wire logic clock,
   input wire logic hostRun,
   output logic [12:0] tapePins
);
   logic [11:0] pinsReg = '0;
   // host running level passes straight through to the top pin
   assign tapePins = {hostRun, pinsReg};
   // marks settle before the strobe and stay past it; the sync lags 4 edges
   task automatic strobe(input logic [11:0] marks);
      @(posedge clock);
      pinsReg <= marks & 12'hffe;
      repeat (2) @(posedge clock);
      pinsReg <= marks | 12'h001;
      repeat (2) @(posedge clock);
      pinsReg <= marks & 12'hffe;
      repeat (6) @(posedge clock);
      pinsReg <= '0;
      repeat (4) @(posedge clock);
   endtask : strobe
endmodule : twc_tape_model
`default_nettype wire

// ---- tape_word_transfer_control_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tape_word_transfer_control_tb;
   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   logic clock = 0;
   logic nrst = 0;
   logic wbCycI = 0;
   logic wbStbI = 0;
   logic wbWeI = 0;
   logic hostRun = 1;
   logic unitUnable = 0;
   logic [3:0] wbSelI = 4'hf;
   logic [3:0] selLanes = 4'hf;
   logic interchangePulse, skipEnable, writePermit;
   int xchCount = 0;
   logic [7:0] wbAdrI = '0;
   logic [31:0] wbDatI = '0;
   logic [31:0] wbDatO;
   logic wbAckO, wordReadyFlag, blockEndFlag, faultFlag, breakRequest, runOut, reverseOut;
   logic [7:0] modeLines, unitLines;
   logic [12:0] tapePins;
   logic [17:0] tapeWord = '0;
   logic [31:0] seed = 32'h0000_50fd;
   logic [31:0] expQ[$];
   int fails = 0;
   int checksDone = 0;
   int cycles = 0;
   // 25 MHz clock
   always #20 clock = ~clock;
   twc_ctrl #(.BUSY_CYC(20), .STOPW_CYC(10)) DUT (.clock(clock), .nrst(nrst),
      .wbCycI(wbCycI), .wbStbI(wbStbI), .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbSelI(wbSelI),
      .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAckO(wbAckO), .tapePins(tapePins),
      .unitUnable(unitUnable), .tapeWord(tapeWord), .writeWord(),
      .interchangePulse(interchangePulse),
      .checksumWritePulse(), .shiftOnZeroPhase(), .wordReadyFlag(wordReadyFlag),
      .blockEndFlag(blockEndFlag), .faultFlag(faultFlag), .breakRequest(breakRequest),
      .skipEnable(skipEnable), .runOut(runOut), .reverseOut(reverseOut),
      .writePermit(writePermit),
      .modeLines(modeLines), .unitLines(unitLines));
   twc_tape_model TAPE (.clock(clock), .hostRun(hostRun), .tapePins(tapePins));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checksDone, fails);
      if (fails == 0 && checksDone > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : complete_run
   // classic single cycle; request held until ack is sampled high
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      @(posedge clock);
      wbCycI <= 1'b1;
      wbStbI <= 1'b1;
      wbWeI <= we;
      wbAdrI <= adr;
      wbSelI <= selLanes;
      wbDatI <= dat;
      do @(posedge clock); while (wbAckO !== 1'b1);
      wbCycI <= 1'b0;
      wbStbI <= 1'b0;
   endtask : wb
   task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
      expQ.push_back(exp);
      wb(1'b0, adr, 32'h0000_0000);
   endtask : rd
   // read results compared in arrival order; timeout ends a hang
   always @(posedge clock)
   begin
      cycles++;
      if (interchangePulse === 1'b1)
         xchCount++;
      if (cycles > 20000)
      begin
         fails++;
         complete_run();
      end
      else if (wbAckO === 1'b1 && wbCycI && !wbWeI)
         check("read data", wbDatO, expQ.pop_front());
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      rd(8'h00, 32'h0000_0000);
      rd(8'h10, 32'h0000_0000);
      for (int c = 0; c < 10; c++)
      begin
         wb(1'b1, 8'h08, 32'(c) << 12);
         @(posedge clock);
         check("unit", 32'(unitLines), (c > 0 && c < 9) ? 32'h1 << (c - 1) : 0);
      end
      // byte lanes off: the select write must leave the unit alone
      selLanes = 4'h0;
      wb(1'b1, 8'h08, 32'h0000_3000);
      selLanes = 4'hf;
      rd(8'h08, 32'h0000_9000);
      // unable level alone raises the fault and shows in status
      unitUnable <= 1'b1;
      rd(8'h00, 32'h0000_8200);
      unitUnable <= 1'b0;
      // search: block number moved with a flag, then a missed word
      seed = xorshift(seed);
      tapeWord <= seed[17:0];
      wb(1'b1, 8'h04, 32'h0000_0021);
      @(posedge clock);
      check("search mode", 32'(modeLines), 32'h0000_0002);
      rd(8'h00, 32'h0000_2000);
      TAPE.strobe(12'h004);
      check("flag and break", {wordReadyFlag, breakRequest, skipEnable}, 32'h0000_0007);
      check("interchange", xchCount, 1);
      rd(8'h00, 32'h0002_2000);
      rd(8'h0c, {14'h0, tapeWord});
      @(posedge clock);
      check("flag cleared", 32'(wordReadyFlag), 0);
      TAPE.strobe(12'h004);
      TAPE.strobe(12'h004);
      check("fault", 32'(faultFlag), 1);
      rd(8'h00, 32'h0002_a800);
      TAPE.strobe(12'h400);
      check("end stops", {runOut, modeLines}, 0);
      // motion control
      wb(1'b1, 8'h04, 32'h0000_0020);
      wb(1'b1, 8'h04, 32'h0000_0010);
      @(posedge clock);
      check("stop keeps dir", {runOut, reverseOut}, 0);
      wb(1'b1, 8'h04, 32'h0000_0030);
      @(posedge clock);
      check("reverse run", {runOut, reverseOut, modeLines}, 32'h0000_0301);
      rd(8'h04, 32'h0000_0030);
      hostRun <= 1'b0;
      repeat (8) @(posedge clock);
      check("halt", 32'(runOut), 0);
      hostRun <= 1'b1;
      repeat (8) @(posedge clock);
      // read mode: flags only inside the read window
      seed = xorshift(seed);
      tapeWord <= seed[17:0];
      wb(1'b1, 8'h04, 32'h0000_0022);
      TAPE.strobe(12'h040);
      check("read flag", 32'(wordReadyFlag), 1);
      rd(8'h0c, {14'h0, tapeWord});
      TAPE.strobe(12'h000);
      check("no window", 32'(wordReadyFlag), 0);
      // write mode: entry flag, cleared by the word write
      wb(1'b1, 8'h04, 32'h0000_0023);
      repeat (3) @(posedge clock);
      check("write entry", {wordReadyFlag, writePermit}, 32'h0000_0003);
      seed = xorshift(seed);
      wb(1'b1, 8'h0c, {14'h0, seed[17:0]});
      @(posedge clock);
      check("write cleared", 32'(wordReadyFlag), 0);
      // a stop during the shift time is held, then carried out
      wb(1'b1, 8'h04, 32'h0000_0000);
      @(posedge clock);
      check("stop held", 32'(runOut), 1);
      repeat (25) @(posedge clock);
      check("stop applied", 32'(runOut), 0);
      complete_run();
   end
endmodule : tape_word_transfer_control_tb
`default_nettype wire
